// >>> dti_consts.vh
// Constants for the drive terminal input/output block
`ifndef DTI_CONSTS_VH
`define DTI_CONSTS_VH
`define DTI_CLK_HZ 25000000
`define DTI_IN_TICK_US 2000
`define DTI_IN_TICK_CYC ((`DTI_CLK_HZ / 1000000) * `DTI_IN_TICK_US)
`define DTI_OUT_TICK_US 1000
`define DTI_OUT_TICK_CYC ((`DTI_CLK_HZ / 1000000) * `DTI_OUT_TICK_US)
`define DTI_AIN_TICK_US 4000
`define DTI_AIN_TICK_CYC ((`DTI_CLK_HZ / 1000000) * `DTI_AIN_TICK_US)
`define DTI_AIN_LOW_MV 1700
`define DTI_AIN_HIGH_MV 3900
`define DTI_AIN_FULL_MV 10000
`define DTI_ADC_BITS 10
`define DTI_ADC_FULL 1023
`define DTI_IN_TICK_LOAD 16'hC34F
`define DTI_OUT_TICK_LOAD 16'h61A7
`define DTI_AIN_TICK_LOAD 17'h1869F
`define DTI_AIN_LOW_CODE 10'h0AD
`define DTI_AIN_HIGH_CODE 10'h18E
`define DTI_FN_OFF 8'h00
`define DTI_FN_RUN 8'h01
`define DTI_FN_RUN_REV 8'h02
`define DTI_FN_COAST 8'h03
`define DTI_FN_QUICK 8'h04
`define DTI_FN_ACK 8'h09
`define DTI_FN_INCH_R 8'h0A
`define DTI_FN_INCH_L 8'h0B
`define DTI_FN_REV 8'h0C
`define DTI_FN_POT_UP 8'h0D
`define DTI_FN_POT_DN 8'h0E
`define DTI_FN_FIX_DIR 8'h0F
`define DTI_FN_FIX_RUN 8'h10
`define DTI_FN_FIX_BIN 8'h11
`define DTI_FN_DCBRAKE 8'h19
`define DTI_FN_TRIP 8'h1D
`define DTI_FN_NO_ADD 8'h21
`define DTI_FN_FREE 8'h63
`define DTI_SRC_TERMINAL 2'h2
`define DTI_SRC_INPUTS 2'h0
`define DTI_SRC_STATUS1 2'h1
`define DTI_SRC_STATUS2 2'h2
`define DTI_AT_UNI_V 2'h0
`define DTI_AT_BI_V 2'h1
`define DTI_AT_CUR 2'h2
`endif

// >>> dti_terminal_io.v
// Drive terminal binary inputs, relay outputs and analog input channels
`timescale 1ns/1ps
`include "dti_consts.vh"
module dti_terminal_io (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Terminal pins
  input wire [5:0] din_pin,
  input wire [9:0] ain0_code,
  input wire [9:0] ain1_code,
  // Input configuration
  input wire input_polarity_setting,
  input wire [2:0] input_debounce_setting,
  input wire [63:0] input_function_selector,
  input wire [1:0] command_source_selector,
  input wire [5:0] run_command_sink,
  input wire [5:0] coast_sink,
  input wire [5:0] ack_sink,
  // Analog configuration
  input wire [1:0] ain0_type,
  input wire [1:0] ain1_type,
  input wire [3:0] analog_filter_time,
  input wire [9:0] ain_gain,
  input wire [9:0] ain_dead_zone,
  // Drive status words
  input wire [15:0] status_word1,
  input wire [15:0] status_word2,
  // Relay selectors
  input wire [17:0] output_source_selector,
  // Outputs
  output reg [7:0] input_state_word,
  output reg normal_ramp_stop,
  output reg run_cmd,
  output reg run_reverse,
  output reg coast_stop,
  output reg quick_ramp_stop,
  output reg fault_ack,
  output reg inch_right,
  output reg inch_left,
  output reg reverse_cmd,
  output reg motor_potentiometer_up,
  output reg motor_potentiometer_down,
  output reg [2:0] fixed_setpoint_sel,
  output reg fixed_setpoint_run,
  output reg dc_brake_enable,
  output reg ext_trip,
  output reg add_setpoint_disable,
  output reg [2:0] relay_out,
  output reg [9:0] ain0_value,
  output reg [9:0] ain1_value,
  output reg [1:0] ain_type_fault
);

  // ==========================================
  // Tick generators
  reg [15:0] in_cnt;
  reg [15:0] out_cnt;
  reg [16:0] ain_cnt;
  wire in_tick;
  wire out_tick;
  wire ain_tick;
  assign in_tick = (in_cnt == 16'h0000);
  assign out_tick = (out_cnt == 16'h0000);
  assign ain_tick = (ain_cnt == 17'h00000);
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_cnt <= 16'h0000;
      out_cnt <= 16'h0000;
      ain_cnt <= 17'h00000;
    end else begin
      in_cnt <= in_tick ? `DTI_IN_TICK_LOAD : in_cnt - 16'h0001;
      out_cnt <= out_tick ? `DTI_OUT_TICK_LOAD : out_cnt - 16'h0001;
      ain_cnt <= ain_tick ? `DTI_AIN_TICK_LOAD : ain_cnt - 17'h00001;
    end
  end

  // ==========================================
  // Pin synchronisers
  reg [5:0] din_s1;
  reg [5:0] din_s2;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      din_s1 <= 6'h00;
      din_s2 <= 6'h00;
    end else begin
      din_s1 <= din_pin;
      din_s2 <= din_s1;
    end
  end

  // ==========================================
  // Analog channels
  reg [19:0] filt0;
  reg [19:0] filt1;
  reg [1:0] ain_bin;
  wire [9:0] f0;
  wire [9:0] f1;
  assign f0 = filt0[19:10];
  assign f1 = filt1[19:10];

  function [19:0] smooth;
    input [19:0] acc;
    input [9:0] code;
    input [3:0] sh;
    reg [20:0] diff;
    reg [20:0] step;
    begin
      diff = {1'b0, code, 10'h000} - {1'b0, acc};
      step = $signed(diff) >>> sh;
      smooth = acc + step[19:0];
    end
  endfunction

  function [9:0] scale_dz;
    input [9:0] v;
    input [9:0] gain;
    input [9:0] dz;
    reg [19:0] p;
    begin
      p = v * gain;
      if (p[18:9] <= dz)
        scale_dz = 10'h000;
      else
        scale_dz = p[19] ? 10'h3FF : p[18:9] - dz;
    end
  endfunction

  function bin_level;
    input [9:0] v;
    input prev;
    begin
      if (v < `DTI_AIN_LOW_CODE)
        bin_level = 1'b0;
      else if (v > `DTI_AIN_HIGH_CODE)
        bin_level = 1'b1;
      else
        bin_level = prev;
    end
  endfunction

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      filt0 <= 20'h00000;
      filt1 <= 20'h00000;
      ain0_value <= 10'h000;
      ain1_value <= 10'h000;
      ain_bin <= 2'h0;
      ain_type_fault <= 2'h0;
    end else if (ain_tick) begin
      filt0 <= smooth(filt0, ain0_code, analog_filter_time);
      filt1 <= smooth(filt1, ain1_code, analog_filter_time);
      ain0_value <= scale_dz(f0, ain_gain, ain_dead_zone);
      ain1_value <= (ain1_type == `DTI_AT_BI_V) ? 10'h000 :
        scale_dz(f1, ain_gain, ain_dead_zone);
      ain_type_fault <= {ain1_type == `DTI_AT_BI_V, ain0_type == 2'h3};
      ain_bin <= {bin_level(ain1_code, ain_bin[1]),
        bin_level(ain0_code, ain_bin[0])};
    end
  end

  // ==========================================
  // Polarity and debounce
  wire [7:0] raw_in;
  assign raw_in = {ain_bin, input_polarity_setting ? din_s2 : ~din_s2};
  reg [3:0] deb_cnt [0:7];
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_deb
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          deb_cnt[gi] <= 4'h0;
          input_state_word[gi] <= 1'b0;
        end else if (in_tick) begin
          if (raw_in[gi] == input_state_word[gi])
            deb_cnt[gi] <= 4'h0;
          else if (deb_cnt[gi] >= {1'b0, input_debounce_setting}) begin
            deb_cnt[gi] <= 4'h0;
            input_state_word[gi] <= raw_in[gi];
          end else
            deb_cnt[gi] <= deb_cnt[gi] + 4'h1;
        end
      end
    end
  endgenerate

  // ==========================================
  // Free routing source
  // source number plus bit
  function route_bit;
    input [5:0] sel;
    input [7:0] ins;
    input [15:0] s1;
    input [15:0] s2;
    begin
      case (sel[5:4])
        `DTI_SRC_INPUTS: route_bit = ins[sel[2:0]];
        `DTI_SRC_STATUS1: route_bit = s1[sel[3:0]];
        `DTI_SRC_STATUS2: route_bit = s2[sel[3:0]];
        default: route_bit = 1'b0;
      endcase
    end
  endfunction

  // ==========================================
  // Function decode
  reg [7:0] fn;
  reg [2:0] next_fix;
  reg next_run, next_rev, next_coast, next_quick, next_ack;
  reg next_ir, next_il, next_revc, next_up, next_dn;
  reg next_fixrun, next_dcb, next_trip, next_noadd;
  integer i;
  always @* begin
    next_run = 1'b0;
    next_rev = 1'b0;
    next_coast = 1'b0;
    next_quick = 1'b0;
    next_ack = 1'b0;
    next_ir = 1'b0;
    next_il = 1'b0;
    next_revc = 1'b0;
    next_up = 1'b0;
    next_dn = 1'b0;
    next_fix = 3'h0;
    next_fixrun = 1'b0;
    next_dcb = 1'b0;
    next_trip = 1'b0;
    next_noadd = 1'b0;
    fn = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      fn = input_function_selector[i*8 +: 8];
      if (input_state_word[i]) begin
        case (fn)
          `DTI_FN_RUN: next_run = 1'b1;
          `DTI_FN_RUN_REV: begin
            next_run = 1'b1;
            next_rev = 1'b1;
          end
          `DTI_FN_COAST: next_coast = 1'b1;
          `DTI_FN_QUICK: next_quick = 1'b1;
          `DTI_FN_ACK: next_ack = 1'b1;
          `DTI_FN_INCH_R: next_ir = 1'b1;
          `DTI_FN_INCH_L: next_il = 1'b1;
          `DTI_FN_REV: next_revc = 1'b1;
          `DTI_FN_DCBRAKE: next_dcb = 1'b1;
          `DTI_FN_TRIP: next_trip = 1'b1;
          `DTI_FN_NO_ADD: next_noadd = 1'b1;
          `DTI_FN_POT_UP: next_up = 1'b1;
          `DTI_FN_POT_DN: next_dn = 1'b1;
          `DTI_FN_FIX_DIR:
            next_fix = (i < 3) ? next_fix | (3'h1 << i) : next_fix;
          `DTI_FN_FIX_RUN, `DTI_FN_FIX_BIN: begin
            next_fix = (i < 3) ? next_fix | (3'h1 << i) : next_fix;
            next_fixrun = 1'b1;
          end
          `DTI_FN_FREE: ;
          default: next_ack = next_ack;
        endcase
      end
    end
  end

  // ==========================================
  // Command outputs
  wire term_en;
  wire rt_run;
  wire rt_coast;
  wire rt_ack;
  assign term_en = (command_source_selector == `DTI_SRC_TERMINAL);
  assign rt_run = route_bit(run_command_sink, input_state_word,
    status_word1, status_word2);
  assign rt_coast = route_bit(coast_sink, input_state_word,
    status_word1, status_word2);
  assign rt_ack = route_bit(ack_sink, input_state_word,
    status_word1, status_word2);
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run_cmd <= 1'b0;
      normal_ramp_stop <= 1'b1;
      run_reverse <= 1'b0;
      coast_stop <= 1'b0;
      quick_ramp_stop <= 1'b0;
      fault_ack <= 1'b0;
      inch_right <= 1'b0;
      inch_left <= 1'b0;
      reverse_cmd <= 1'b0;
      motor_potentiometer_up <= 1'b0;
      motor_potentiometer_down <= 1'b0;
      fixed_setpoint_sel <= 3'h0;
      fixed_setpoint_run <= 1'b0;
      dc_brake_enable <= 1'b0;
      ext_trip <= 1'b0;
      add_setpoint_disable <= 1'b0;
    end else begin
      run_cmd <= term_en & (next_run | rt_run | next_fixrun);
      normal_ramp_stop <= ~(term_en & (next_run | rt_run | next_fixrun));
      run_reverse <= term_en & next_rev;
      coast_stop <= next_coast | rt_coast;
      quick_ramp_stop <= next_quick;
      fault_ack <= next_ack | rt_ack;
      inch_right <= term_en & next_ir;
      inch_left <= term_en & next_il;
      reverse_cmd <= next_revc;
      motor_potentiometer_up <= next_up;
      motor_potentiometer_down <= next_dn;
      fixed_setpoint_sel <= next_fix;
      fixed_setpoint_run <= term_en & next_fixrun;
      dc_brake_enable <= next_dcb;
      ext_trip <= next_trip;
      add_setpoint_disable <= next_noadd;
    end
  end

  // ==========================================
  // Relay outputs
  // relays from input state or status bits
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_rel
      always @(posedge clk_sys or posedge rst) begin
        if (rst)
          relay_out[gi] <= 1'b0;
        else if (out_tick)
          relay_out[gi] <= route_bit(output_source_selector[gi*6 +: 6],
            input_state_word, status_word1, status_word2);
      end
    end
  endgenerate

endmodule // dti_terminal_io

// >>> dti_chk.sv
// Assertion checker for the drive terminal block
`timescale 1ns/1ps
module dti_chk (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Watched ports
  input wire [63:0] input_function_selector,
  input wire [1:0] command_source_selector,
  input wire [5:0] run_command_sink,
  input wire [15:0] status_word1,
  input wire [1:0] ain1_type,
  input wire [7:0] input_state_word,
  input wire normal_ramp_stop,
  input wire run_cmd,
  input wire coast_stop,
  input wire ext_trip,
  input wire [2:0] relay_out,
  input wire [9:0] ain1_value,
  input wire [1:0] ain_type_fault
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ====
  // Gap counters
  reg [7:0] isw_q;
  reg [2:0] rly_q;
  reg [17:0] gi;
  reg [17:0] gr;
  reg [17:0] gb;
  reg si;
  reg sr;
  reg rst_q = 1'b0;
  always @(posedge clk_sys) rst_q <= rst;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      isw_q <= 8'h00;
      rly_q <= 3'h0;
      gi <= 18'h00000;
      gr <= 18'h00000;
      gb <= 18'h00000;
      si <= 1'b0;
      sr <= 1'b0;
    end else begin
      isw_q <= input_state_word;
      rly_q <= relay_out;
      si <= si | (input_state_word != isw_q);
      sr <= sr | (relay_out != rly_q);
      gi <= (input_state_word != isw_q) ? 18'h00000 : gi + {17'h0, ~&gi};
      gr <= (relay_out != rly_q) ? 18'h00000 : gr + {17'h0, ~&gr};
      gb <= (ain1_type != 2'h1) ? 18'h00000 : gb + {17'h0, ~&gb};
    end
  end
  // ====
  // Properties
  AST_RESET: assert property (disable iff (1'b0) rst && rst_q |->
    normal_ramp_stop
    && relay_out == 3'h0 && input_state_word == 8'h00)
    else $error("reset values wrong");
  AST_TRIP: assert property ((
    input_function_selector[7:0] == 8'h1D && input_state_word[0])[*2]
    |-> ext_trip) else $error("trip command missing");
  AST_COAST: assert property ((
    input_function_selector[15:8] == 8'h03 && input_state_word[1])[*2]
    |-> coast_stop) else $error("coast stop missing");
  AST_GATE: assert property (
    (command_source_selector != 2'h2)[*2] |-> !run_cmd)
    else $error("run without terminal source");
  AST_ROUTE: assert property ((input_function_selector == 64'h0 &&
    command_source_selector == 2'h2 && run_command_sink == 6'h13)[*2]
    |-> run_cmd == $past(status_word1[3])) else $error("route wrong");
  AST_ISW_GAP: assert property (
    si && input_state_word != isw_q |-> gi >= 18'd49999)
    else $error("input word changed off tick");
  AST_RLY_GAP: assert property (
    sr && relay_out != rly_q |-> gr >= 18'd24999)
    else $error("relay changed off tick");
  AST_BIPOLAR: assert property (
    gb >= 18'h186A1 |-> ain1_value == 10'h000 && ain_type_fault[1])
    else $error("bipolar not refused");
  cover property (input_state_word[6:0] == 7'h7F);
  cover property (relay_out == 3'h7);
  cover property (run_cmd);
endmodule // dti_chk

bind dti_terminal_io dti_chk i_chk (.*);

// >>> dti_switch_model.sv
// Terminal switches and analog sources beside the drive
`timescale 1ns/1ps
module dti_switch_model (
  // Switch and source settings
  input wire [5:0] contact,
  input wire rail_24v,
  input wire [13:0] mv0,
  input wire [13:0] mv1,
  // Terminal levels
  output wire [5:0] din_pin,
  output wire [9:0] ain0_code,
  output wire [9:0] ain1_code
);
  // Open contact leaves the pin at the other rail
  assign din_pin = rail_24v ? contact : ~contact;
  assign ain0_code = 10'((mv0 * 32'd1023) / 32'd10000);
  assign ain1_code = 10'((mv1 * 32'd1023) / 32'd10000);
endmodule // dti_switch_model

// >>> dti_terminal_io_tb.sv
// Self-checking bench for the drive terminal block
`timescale 1ns/1ps
module dti_terminal_io_tb;
  // ====
  // Signals
  reg clk_sys = 0, rst = 1, input_polarity_setting = 1, rail_24v = 1;
  reg [5:0] contact = 6'h3F;
  reg [13:0] mv0 = 14'd5000, mv1 = 14'd5000;
  wire [5:0] din_pin;
  wire [9:0] ain0_code, ain1_code, ain0_value, ain1_value;
  reg [2:0] input_debounce_setting = 3'h0;
  reg [63:0] input_function_selector = 64'h0;
  reg [1:0] command_source_selector = 2'h2;
  reg [5:0] run_command_sink = 6'h30, coast_sink = 6'h30, ack_sink = 6'h30;
  reg [1:0] ain0_type = 2'h1, ain1_type = 2'h1;
  reg [3:0] analog_filter_time = 4'h0;
  reg [9:0] ain_gain = 10'h200, ain_dead_zone = 10'h000;
  reg [15:0] status_word1 = 16'h0008, status_word2 = 16'h0040;
  reg [17:0] output_source_selector = {6'h05, 6'h26, 6'h13};
  wire [7:0] input_state_word;
  wire normal_ramp_stop, run_cmd, run_reverse, coast_stop, quick_ramp_stop;
  wire fault_ack, inch_right, inch_left, reverse_cmd, fixed_setpoint_run;
  wire motor_potentiometer_up, motor_potentiometer_down, dc_brake_enable;
  wire ext_trip, add_setpoint_disable;
  wire [2:0] fixed_setpoint_sel, relay_out;
  wire [1:0] ain_type_fault;
  wire [13:0] cmds = {run_cmd, run_reverse, coast_stop, quick_ramp_stop,
    fault_ack, inch_right, inch_left, reverse_cmd, motor_potentiometer_up,
    motor_potentiometer_down, fixed_setpoint_run, dc_brake_enable, ext_trip,
    add_setpoint_disable};
  integer bad_count = 0, n_checks = 0, cyc = 0, i;
  dti_terminal_io i_dut (.*);
  dti_switch_model i_sw (.contact(contact), .rail_24v(rail_24v),
    .mv0(mv0), .mv1(mv1), .din_pin(din_pin), .ain0_code(ain0_code),
    .ain1_code(ain1_code));
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 110000) begin
      bad_count = bad_count + 1;
      finish_test;
    end
  end
  // ====
  // Helpers
  task finish_test;
    begin
      if (bad_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("Error %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wait_isw(input [6:0] exp);
    begin
      i = 0;
      while (input_state_word[6:0] !== exp && i < 60000) begin
        @(negedge clk_sys);
        i = i + 1;
      end
    end
  endtask
  task codes(input [63:0] sel, input [1:0] src, input [13:0] exp,
    input [13:0] msk);
    begin
      @(negedge clk_sys);
      input_function_selector = sel;
      command_source_selector = src;
      repeat (3) @(negedge clk_sys);
      chk(cmds & msk, exp);
    end
  endtask
  // ====
  // Scenarios
  task t_on;
    begin
      wait_isw(7'h7F);
      chk(input_state_word[6:0], 7'h7F);
      chk(input_state_word[6], 1'b1);
      repeat (26000) @(negedge clk_sys);
      chk(relay_out, 3'h7);
      chk({ain_type_fault, ain1_value}, {2'h2, 10'h000});
    end
  endtask
  task t_decode;
    begin
      codes(64'h00016321_0904031D, 2'h2, 14'h2E03, 14'h3FFF);
      chk(normal_ramp_stop, 1'b0);
      codes(64'h630D190B_0A0C0E02, 2'h2, 14'h11F4, 14'h1FFF);
      codes(64'h00000000_00110F10, 2'h2, 14'h0008, 14'h1FFF);
      chk(fixed_setpoint_sel, 3'h7);
      codes(64'h00016321_0904031D, 2'h0, 14'h0000, 14'h2000);
      chk(normal_ramp_stop, 1'b1);
    end
  endtask
  task t_route;
    begin
      run_command_sink = 6'h13;
      codes(64'h0, 2'h2, 14'h2000, 14'h2000);
      run_command_sink = 6'h00;
      codes(64'h63, 2'h2, 14'h2000, 14'h2000);
      run_command_sink = 6'h30;
      codes(64'h63, 2'h2, 14'h0000, 14'h3FFF);
    end
  endtask
  task t_off;
    begin
      input_polarity_setting = 0;
      status_word2 = 16'h0000;
      output_source_selector = {6'h10, 6'h26, 6'h13};
      wait_isw(7'h40);
      repeat (4) @(negedge clk_sys);
      chk(input_state_word[6:0], 7'h40);
      chk(relay_out, 3'h1);
      chk(ain0_value, 10'h1FF);
    end
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    rst = 0;
    @(negedge clk_sys);
    t_on;
    t_decode;
    t_route;
    t_off;
    finish_test;
  end
endmodule // dti_terminal_io_tb
